// ===== hdl/signal_path_ctrl.sv
`timescale 1ns/10ps
// Contract
// - Per-channel reference select, first after reset
// - Channel is positive minus negative input
// - Seven channels large, four small variant
// - Gain is fixed stage times programmable
// - Gain kept per channel
// - Gain sixteen or more forces buffer
// - Internal or external clock source
// - Crystal detected stops internal oscillator
// - Eight rates, fastest by default
// - Base rates clock/266240, clock/16640, divided
// - Rate selectable per channel
// - Scanned channel rate divided by n
// - Line rejection only at slow rates
// - Filter frequencies scale with clock
// - General pins drive or read levels
// - Background calibration corrects without interruption
// - Calibration for four differential channels
// - Results delivered in two's complement
module signal_path_ctrl #(
  parameter int  NUM_CH_P    = sig_path_pkg::NUM_CH,
  parameter int  BASE1_DIV_P = sig_path_pkg::BASE1_DIV,
  parameter int  BASE2_DIV_P = sig_path_pkg::BASE2_DIV
) (
  // Clock and reset
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  // Variant strap: high for the small variant
  input  wire logic                                small_variant,
  // Configuration write port
  input  wire logic                                cfg_wr,
  input  wire logic [sig_path_pkg::CH_W-1:0]       cfg_ch,
  input  wire logic [sig_path_pkg::CFG_W-1:0]      cfg_data,
  // Scan control
  input  wire logic                                scan_en,
  input  wire logic [sig_path_pkg::CH_W-1:0]       first_ch,
  input  wire logic [sig_path_pkg::CH_W-1:0]       last_ch,
  // Clock control
  input  wire logic                                ext_clk_sel,
  input  wire logic                                ext_clk_detect_mode,
  input  wire logic                                crystal_present,
  // Calibration
  input  wire logic [1:0]                          cal_mode,
  // Modulator raw result, same clock
  input  wire logic                                raw_valid,
  input  wire logic [sig_path_pkg::RES_W-1:0]      raw_data,
  // General pins
  input  wire logic [sig_path_pkg::NUM_GPIO-1:0]   gpio_dir,
  input  wire logic [sig_path_pkg::NUM_GPIO-1:0]   gpio_out_val,
  input  wire logic [sig_path_pkg::NUM_GPIO-1:0]   general_pins_in,
  output      logic [sig_path_pkg::NUM_GPIO-1:0]   general_pins_out,
  output      logic [sig_path_pkg::NUM_GPIO-1:0]   general_pins_oe,
  output      logic [sig_path_pkg::NUM_GPIO-1:0]   gpio_read_val,
  // Active channel path settings
  output      logic [sig_path_pkg::CH_W-1:0]       active_ch,
  output      logic                                ref_sel,
  output      logic [sig_path_pkg::IDX_W-1:0]      positive_input_index,
  output      logic [sig_path_pkg::IDX_W-1:0]      negative_input_index,
  output      logic                                fixed_gain_stage,
  output      logic [1:0]                          programmable_gain_stage,
  output      logic [7:0]                          total_gain,
  output      logic                                unity_input_buffer,
  output      logic                                line_reject_active,
  // Clock status
  output      logic                                int_osc_en,
  output      logic                                use_ext_clk,
  // Conversion results
  output      logic                                conv_done,
  output      logic [sig_path_pkg::CH_W-1:0]       result_ch,
  output      logic [sig_path_pkg::RES_W-1:0]      result_data,
  // Configuration error
  output      logic                                cfg_conflict
);
  localparam int ODR_CW = 4;
  typedef logic [sig_path_pkg::RES_W-1:0] res_t;

  initial begin
    if (NUM_CH_P != sig_path_pkg::NUM_CH) $error("channel count unsupported");
    if (BASE1_DIV_P <= BASE2_DIV_P) $error("base dividers out of order");
  end

  // Total gain from the gain code
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    logic [7:0] g;
    g = 8'h01 << code[1:0];
    if (code[sig_path_pkg::FGA_BIT]) begin
      g = g << 4;
    end
    return g;
  endfunction

  // Rate code to divider over its base: codes 0-3 slow base, 4-7 fast base
  function automatic logic [ODR_CW-1:0] rate_div(input logic [2:0] code);
    return ODR_CW'(4'h8 >> code[1:0]);
  endfunction

  logic                               ref_sel_ff   [NUM_CH_P];
  logic [sig_path_pkg::IDX_W-1:0]     pos_ff       [NUM_CH_P];
  logic [sig_path_pkg::IDX_W-1:0]     neg_ff       [NUM_CH_P];
  logic                               buf_ff       [NUM_CH_P];
  logic [sig_path_pkg::GAIN_W-1:0]    gain_ff      [NUM_CH_P];
  logic [sig_path_pkg::ODR_W-1:0]     odr_ff       [NUM_CH_P];
  logic [sig_path_pkg::CH_W-1:0]      active_ch_ff;
  logic [ODR_CW-1:0]                  sub_cnt_ff;
  logic [1:0]                         small_sync_ff;
  logic                               ext_clk_ff;
  logic                               int_osc_ff;
  logic [1:0]                         xtal_sync_ff;
  logic [sig_path_pkg::NUM_GPIO-1:0]  gpio_s1_ff;
  logic [sig_path_pkg::NUM_GPIO-1:0]  gpio_s2_ff;
  logic                               conv_done_ff;
  logic [sig_path_pkg::CH_W-1:0]      result_ch_ff;
  logic [sig_path_pkg::RES_W-1:0]     result_ff;
  logic                               tick1;
  logic                               tick2;
  logic                               base_tick;
  logic                               rate_tick;
  logic [sig_path_pkg::CH_W-1:0]      max_ch;
  logic [sig_path_pkg::CH_W-1:0]      nxt_active_ch;
  logic                               cfg_ok;
  logic                               cal_ch;
  logic                               cal_on;
  logic [sig_path_pkg::COEF_W-1:0]    ofs_coef;
  logic                               coef_wr;
  logic [sig_path_pkg::COEF_W-1:0]    coef_wdata;
  logic [sig_path_pkg::RES_W-1:0]     corrected;
  logic [sig_path_pkg::NUM_DIFF_CH-1:0] coef_seen_ff;
  logic                               coef_live_ff;

  // Strap pin is asynchronous, so two stages before use
  always_ff @(posedge sys_clk) begin
    small_sync_ff <= {small_sync_ff[0], small_variant};
  end

  // Small variant has four channels only
  assign max_ch = small_sync_ff[1] ? 3'h3 : 3'(NUM_CH_P - 1);

  // Reject writes that clash with the second reference or the variant
  always_comb begin
    cfg_ok = (cfg_ch <= max_ch);
    if (cfg_data[sig_path_pkg::CFG_REF_POS]) begin
      if (cfg_data[sig_path_pkg::CFG_POS_LSB +: 3] inside {sig_path_pkg::REF2_PIN_A, sig_path_pkg::REF2_PIN_B} ||
          cfg_data[sig_path_pkg::CFG_NEG_LSB +: 3] inside {sig_path_pkg::REF2_PIN_A, sig_path_pkg::REF2_PIN_B}) begin
        cfg_ok = 1'b0;
      end
    end
  end

  // Flag a refused write, held until the next write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_conflict <= 1'b0;
    end else if (cfg_wr) begin
      cfg_conflict <= ~cfg_ok;
    end
  end

  // Per-channel configuration fields
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH_P; i++) begin
        ref_sel_ff[i] <= sig_path_pkg::REF_SEL_RST;
        pos_ff[i]     <= sig_path_pkg::POS_RST;
        neg_ff[i]     <= sig_path_pkg::NEG_RST;
        buf_ff[i]     <= sig_path_pkg::BUF_RST;
        gain_ff[i]    <= sig_path_pkg::GAIN_RST;
        odr_ff[i]     <= sig_path_pkg::ODR_RST;
      end
    end else if (cfg_wr && cfg_ok) begin
      ref_sel_ff[cfg_ch] <= cfg_data[sig_path_pkg::CFG_REF_POS];
      pos_ff[cfg_ch]     <= cfg_data[sig_path_pkg::CFG_POS_LSB +: 3];
      neg_ff[cfg_ch]     <= cfg_data[sig_path_pkg::CFG_NEG_LSB +: 3];
      buf_ff[cfg_ch]     <= cfg_data[sig_path_pkg::CFG_BUF_POS];
      gain_ff[cfg_ch]    <= cfg_data[sig_path_pkg::CFG_GAIN_LSB +: 3];
      odr_ff[cfg_ch]     <= cfg_data[sig_path_pkg::CFG_ODR_LSB +: 3];
    end
  end

  // Clock source; detection stops the internal oscillator only once a crystal is seen
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xtal_sync_ff <= 2'h0;
    end else begin
      xtal_sync_ff <= {xtal_sync_ff[0], crystal_present};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_clk_ff <= 1'b0;
      int_osc_ff <= 1'b1;
    end else begin
      ext_clk_ff <= ext_clk_sel | (ext_clk_detect_mode & xtal_sync_ff[1]);
      int_osc_ff <= ~(ext_clk_detect_mode & xtal_sync_ff[1]);
    end
  end

  assign use_ext_clk = ext_clk_ff;
  assign int_osc_en  = int_osc_ff;

  // Base rate ticks: sys_clk stands in for the modulator clock
  rate_divider #(.DIV(BASE1_DIV_P)) u_base1 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tick1)
  );

  rate_divider #(.DIV(BASE2_DIV_P)) u_base2 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (tick2)
  );

  // Code bit 2 picks the fast base; filter response follows the clock the same way
  assign base_tick = odr_ff[active_ch_ff][2] ? tick2 : tick1;

  // Sub-divide the base by 1, 2, 4 or 8
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sub_cnt_ff <= '0;
    end else if (base_tick) begin
      sub_cnt_ff <= (sub_cnt_ff + 1'b1 >= rate_div(odr_ff[active_ch_ff])) ? '0 : ODR_CW'(sub_cnt_ff + 1'b1);
    end
  end

  assign rate_tick = base_tick && (ODR_CW'(sub_cnt_ff + 1'b1) >= rate_div(odr_ff[active_ch_ff]));

  // Advance the scan on each rate tick, so n channels share one rate
  always_comb begin
    nxt_active_ch = active_ch_ff;
    if (scan_en) begin
      if (active_ch_ff >= last_ch || active_ch_ff >= max_ch) begin
        nxt_active_ch = first_ch;
      end else begin
        nxt_active_ch = active_ch_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_ch_ff <= '0;
    end else if (!scan_en) begin
      active_ch_ff <= (first_ch > max_ch) ? max_ch : first_ch;
    end else if (rate_tick) begin
      active_ch_ff <= nxt_active_ch;
    end
  end

  // Active channel outputs
  assign active_ch               = active_ch_ff;
  assign ref_sel                 = ref_sel_ff[active_ch_ff];
  assign positive_input_index    = pos_ff[active_ch_ff];
  assign negative_input_index    = neg_ff[active_ch_ff];
  assign fixed_gain_stage        = gain_ff[active_ch_ff][sig_path_pkg::FGA_BIT];
  assign programmable_gain_stage = gain_ff[active_ch_ff][1:0];
  assign total_gain              = gain_of(gain_ff[active_ch_ff]);
  assign unity_input_buffer      = (total_gain >= sig_path_pkg::GAIN_BUF_FORCE) | buf_ff[active_ch_ff];
  assign line_reject_active      = (odr_ff[active_ch_ff] <= sig_path_pkg::ODR_LINE_REJ_MAX);

  // Background calibration on differential channels only, never stalls the stream
  assign cal_ch     = (active_ch_ff < 3'(sig_path_pkg::NUM_DIFF_CH));
  assign cal_on     = (cal_mode != sig_path_pkg::CAL_OFF) && cal_ch;
  assign coef_wr    = raw_valid && cal_on && (cal_mode != sig_path_pkg::CAL_EST);
  assign coef_wdata = raw_data >>> 8;

  // Coefficient used only once written; the store has no reset, live lines up with its read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      coef_seen_ff <= '0;
      coef_live_ff <= 1'b0;
    end else begin
      if (coef_wr) begin
        coef_seen_ff[active_ch_ff[1:0]] <= 1'b1;
      end
      coef_live_ff <= coef_seen_ff[active_ch_ff[1:0]];
    end
  end

  cal_coef_mem #(.DEPTH(sig_path_pkg::NUM_DIFF_CH), .W(sig_path_pkg::COEF_W)) u_coef (
    .sys_clk (sys_clk),
    .wr_en   (coef_wr),
    .wr_addr (active_ch_ff[1:0]),
    .wr_data (coef_wdata),
    .rd_addr (active_ch_ff[1:0]),
    .rd_data (ofs_coef)
  );

  // Offset correction in signed arithmetic
  assign corrected = (cal_on && coef_live_ff) ? res_t'($signed(raw_data) - $signed(ofs_coef)) : raw_data;

  // Register the two's complement result
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conv_done_ff <= 1'b0;
      result_ch_ff <= '0;
      result_ff    <= '0;
    end else begin
      conv_done_ff <= raw_valid;
      if (raw_valid) begin
        result_ch_ff <= active_ch_ff;
        result_ff    <= corrected;
      end
    end
  end

  assign conv_done   = conv_done_ff;
  assign result_ch   = result_ch_ff;
  assign result_data = result_ff;

  // General pins: two-stage sync on reads
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpio_s1_ff <= '0;
      gpio_s2_ff <= '0;
    end else begin
      gpio_s1_ff <= general_pins_in;
      gpio_s2_ff <= gpio_s1_ff;
    end
  end

  assign general_pins_out = gpio_out_val;
  assign general_pins_oe  = gpio_dir;
  assign gpio_read_val    = gpio_s2_ff;
endmodule

// ===== hdl/sig_path_pkg.sv
package sig_path_pkg;
  // Channel organisation
  localparam int          NUM_CH          = 7;
  localparam int          NUM_DIFF_CH     = 4;
  localparam int          NUM_GPIO        = 7;
  localparam int          IDX_W           = 3;
  localparam int          GAIN_W          = 3;
  localparam int          ODR_W           = 3;
  localparam int          CH_W            = 3;
  localparam int          RES_W           = 16;
  // Configuration word layout: [0] ref sel, [3:1] pos, [6:4] neg, [7] buf en, [10:8] gain, [13:11] rate
  localparam int          CFG_W           = 14;
  localparam int          CFG_REF_POS     = 0;
  localparam int          CFG_POS_LSB     = 1;
  localparam int          CFG_NEG_LSB     = 4;
  localparam int          CFG_BUF_POS     = 7;
  localparam int          CFG_GAIN_LSB    = 8;
  localparam int          CFG_ODR_LSB     = 11;
  // Reset values
  localparam logic        REF_SEL_RST     = 1'b0;
  localparam logic [2:0]  ODR_RST         = 3'h7;
  localparam logic [2:0]  GAIN_RST        = 3'h0;
  localparam logic [2:0]  POS_RST         = 3'h0;
  localparam logic [2:0]  NEG_RST         = 3'h1;
  localparam logic        BUF_RST         = 1'b0;
  // Gain code: bit 2 selects the fixed 16x stage, bits 1:0 the 1/2/4/8 stage
  localparam int          FGA_BIT         = 2;
  localparam logic [7:0]  GAIN_BUF_FORCE  = 8'h10;
  // Inputs lost when the second reference is chosen
  localparam logic [2:0]  REF2_PIN_A      = 3'h6;
  localparam logic [2:0]  REF2_PIN_B      = 3'h7;
  // Rate generation: clock divisors of the two base rates
  localparam int          BASE1_DIV       = 266240;
  localparam int          BASE2_DIV       = 16640;
  localparam logic [2:0]  ODR_LINE_REJ_MAX = 3'h3;
  // Filter scaling constants
  localparam int          FILT_CLK_DIV    = 256;
  localparam int          FILT_REF_HZ     = 13952;
  // Calibration modes
  typedef enum logic [1:0] {
    CAL_OFF      = 2'h0,
    CAL_OFS_CORR = 2'h1,
    CAL_FULL     = 2'h2,
    CAL_EST      = 2'h3
  } cal_mode_e;
  localparam int          COEF_W          = 16;
endpackage

// ===== hdl/cal_coef_mem.sv
`timescale 1ns/10ps
// Per-channel offset coefficient store, registered read
module cal_coef_mem #(
  parameter int DEPTH = 4,
  parameter int W     = 16
) (
  // Clock
  input  wire logic                       sys_clk,
  // Write port
  input  wire logic                       wr_en,
  input  wire logic [$clog2(DEPTH)-1:0]   wr_addr,
  input  wire logic [W-1:0]               wr_data,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0]   rd_addr,
  output      logic [W-1:0]               rd_data
);
  logic [W-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2) $error("depth too small");
  end

  // Write
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read keeps the timing path short
  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== hdl/rate_divider.sv
`timescale 1ns/10ps
// Free counter producing a one-cycle tick every DIV cycles
module rate_divider #(
  parameter int DIV = 16640
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Tick
  output      logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_ff;

  initial begin
    if (DIV < 2) $error("divider too small");
  end

  // Count modulo DIV
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (cnt_ff == CW'(DIV - 1)) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign tick = (cnt_ff == CW'(DIV - 1));
endmodule

// ===== tb/signal_path_properties.sv
`timescale 1ns/10ps
// Port-level checks on the path controller
module signal_path_properties (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Inputs
  input wire logic        small_variant,
  input wire logic        cfg_wr,
  input wire logic [2:0]  cfg_ch,
  input wire logic [13:0] cfg_data,
  input wire logic        ext_clk_detect_mode,
  input wire logic        crystal_present,
  input wire logic        raw_valid,
  input wire logic [6:0]  gpio_dir,
  input wire logic [6:0]  gpio_out_val,
  input wire logic [6:0]  general_pins_in,
  // Outputs
  input wire logic [6:0]  general_pins_out,
  input wire logic [6:0]  general_pins_oe,
  input wire logic [6:0]  gpio_read_val,
  input wire logic [2:0]  active_ch,
  input wire logic        fixed_gain_stage,
  input wire logic [1:0]  programmable_gain_stage,
  input wire logic [7:0]  total_gain,
  input wire logic        unity_input_buffer,
  input wire logic        int_osc_en,
  input wire logic        use_ext_clk,
  input wire logic        conv_done,
  input wire logic [2:0]  result_ch,
  input wire logic        cfg_conflict
);
  // One clock domain, so one default clock and disable
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  gain_product_a: assert property (total_gain == ((fixed_gain_stage ? 8'h10 : 8'h01) << programmable_gain_stage))
    else $error("Total gain is not the stage product");
  buffer_force_a: assert property (total_gain >= 8'h10 |-> unity_input_buffer)
    else $error("Buffer not forced at high gain");
  conv_latency_a: assert property (raw_valid |=> conv_done)
    else $error("Sample not answered next cycle");
  conv_cause_a: assert property (conv_done |-> $past(raw_valid) && result_ch == $past(active_ch))
    else $error("Result without sample or wrong channel");
  gpio_drive_a: assert property ((general_pins_oe == gpio_dir) && ((general_pins_out & gpio_dir) == (gpio_out_val & gpio_dir)))
    else $error("General pin drive wrong");
  // Two clean edges needed before the sync stages hold live data
  gpio_read_a: assert property (!$past(rst) && !$past(rst, 2) |-> gpio_read_val == $past(general_pins_in, 2))
    else $error("General pin read value wrong");
  xtal_stop_a: assert property ((ext_clk_detect_mode && crystal_present) [*4] |=> use_ext_clk && !int_osc_en)
    else $error("Oscillator still running with crystal");
  variant_refuse_a: assert property (cfg_wr && $past(small_variant, 2) && cfg_ch > 3'h3 |=> cfg_conflict)
    else $error("Missing channel not refused");
  ref_refuse_a: assert property (cfg_wr && cfg_data[0] && (cfg_data[3:1] >= 3'h6 || cfg_data[6:4] >= 3'h6) |=> cfg_conflict)
    else $error("Shared reference pin not refused");
  // Main scenarios
  cover property (conv_done);
  cover property (cfg_conflict);
  cover property (use_ext_clk && !int_osc_en);
endmodule

bind signal_path_ctrl signal_path_properties i_signal_path_properties (
  .sys_clk(sys_clk), .rst(rst), .small_variant(small_variant), .cfg_wr(cfg_wr), .cfg_ch(cfg_ch),
  .cfg_data(cfg_data), .ext_clk_detect_mode(ext_clk_detect_mode), .crystal_present(crystal_present),
  .raw_valid(raw_valid), .gpio_dir(gpio_dir), .gpio_out_val(gpio_out_val), .general_pins_in(general_pins_in),
  .general_pins_out(general_pins_out), .general_pins_oe(general_pins_oe), .gpio_read_val(gpio_read_val),
  .active_ch(active_ch), .fixed_gain_stage(fixed_gain_stage), .programmable_gain_stage(programmable_gain_stage),
  .total_gain(total_gain), .unity_input_buffer(unity_input_buffer), .int_osc_en(int_osc_en),
  .use_ext_clk(use_ext_clk), .conv_done(conv_done), .result_ch(result_ch), .cfg_conflict(cfg_conflict));

// ===== tb/sensor_model.sv
`timescale 1ns/10ps
// Sensor front and pin switches outside the controller
module sensor_model (
  // Clock
  input  wire logic        sys_clk,
  // Pin side
  input  wire logic [6:0]  general_pins_out,
  input  wire logic [6:0]  general_pins_oe,
  input  wire logic [6:0]  ext_level,
  output      logic [6:0]  general_pins_in,
  // Sample side
  output      logic        raw_valid,
  output      logic [15:0] raw_data
);
  initial begin
    raw_valid = 1'b0;
    raw_data  = 16'h0000;
  end
  // Wire level: device where enabled, switch elsewhere; only high or low
  assign general_pins_in = (general_pins_oe & general_pins_out) | (~general_pins_oe & ext_level);
  // One signed sample; data inverts after release so stale values never match
  task automatic send(input logic [15:0] v);
    @(posedge sys_clk);
    raw_valid <= 1'b1;
    raw_data  <= v;
    @(posedge sys_clk);
    raw_valid <= 1'b0;
    raw_data  <= ~v;
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        sys_clk, rst, small_variant, cfg_wr, scan_en, ext_clk_sel, ext_clk_detect_mode, crystal_present;
  logic [2:0]  cfg_ch, first_ch, last_ch, lp, ln, i;
  logic [13:0] cfg_data;
  logic [1:0]  cal_mode;
  logic        raw_valid, ref_sel, fixed_gain_stage, unity_input_buffer, line_reject_active;
  logic        int_osc_en, use_ext_clk, conv_done, cfg_conflict;
  logic [15:0] raw_data, result_data, v, w;
  logic [6:0]  gpio_dir, gpio_out_val, general_pins_in, general_pins_out, general_pins_oe, gpio_read_val, ext_level;
  logic [2:0]  active_ch, positive_input_index, negative_input_index, result_ch;
  logic [1:0]  programmable_gain_stage;
  logic [7:0]  total_gain;
  logic [18:0] exp_q[$];
  int          n_mismatch = 0;
  int          num_checks = 0;
  // Short divisors keep rate ticks frequent
  signal_path_ctrl #(.BASE1_DIV_P(64), .BASE2_DIV_P(8)) i_signal_path_ctrl (
    .sys_clk(sys_clk), .rst(rst), .small_variant(small_variant), .cfg_wr(cfg_wr), .cfg_ch(cfg_ch),
    .cfg_data(cfg_data), .scan_en(scan_en), .first_ch(first_ch), .last_ch(last_ch), .ext_clk_sel(ext_clk_sel),
    .ext_clk_detect_mode(ext_clk_detect_mode), .crystal_present(crystal_present), .cal_mode(cal_mode),
    .raw_valid(raw_valid), .raw_data(raw_data), .gpio_dir(gpio_dir), .gpio_out_val(gpio_out_val),
    .general_pins_in(general_pins_in), .general_pins_out(general_pins_out), .general_pins_oe(general_pins_oe),
    .gpio_read_val(gpio_read_val), .active_ch(active_ch), .ref_sel(ref_sel),
    .positive_input_index(positive_input_index), .negative_input_index(negative_input_index),
    .fixed_gain_stage(fixed_gain_stage), .programmable_gain_stage(programmable_gain_stage),
    .total_gain(total_gain), .unity_input_buffer(unity_input_buffer), .line_reject_active(line_reject_active),
    .int_osc_en(int_osc_en), .use_ext_clk(use_ext_clk), .conv_done(conv_done), .result_ch(result_ch),
    .result_data(result_data), .cfg_conflict(cfg_conflict));
  sensor_model i_sensor_model (.sys_clk(sys_clk), .general_pins_out(general_pins_out),
    .general_pins_oe(general_pins_oe), .ext_level(ext_level), .general_pins_in(general_pins_in),
    .raw_valid(raw_valid), .raw_data(raw_data));
  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [13:0] mk(logic r, logic [2:0] p, logic [2:0] n, logic b, logic [2:0] g, logic [2:0] od);
    return {od, g, b, n, p, r};
  endfunction
  // One write, then let the taking edge land
  task automatic wr(input logic [2:0] ch, input logic [13:0] d);
    @(posedge sys_clk);
    cfg_wr   <= 1'b1;
    cfg_ch   <= ch;
    cfg_data <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    #1;
  endtask
  task automatic chk_path(logic r, logic [2:0] p, logic [2:0] n, logic b, logic [2:0] g, logic [2:0] od);
    logic [7:0] eg;
    eg = (g[2] ? 8'h10 : 8'h01) << g[1:0];
    chk(ref_sel === r && positive_input_index === p && negative_input_index === n, "mux fields");
    chk(total_gain === eg && fixed_gain_stage === g[2] && programmable_gain_stage === g[1:0], "gain");
    chk(unity_input_buffer === (b | (eg >= 8'h10)), "buffer");
    chk(line_reject_active === (od <= 3'h3), "line rejection");
  endtask
  // Reset held six cycles; a clean config and clock state must follow
  task automatic do_reset;
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_path(1'b0, 3'h0, 3'h1, 1'b0, 3'h0, 3'h7);
    chk(int_osc_en === 1'b1 && use_ext_clk === 1'b0 && cfg_conflict === 1'b0, "reset state");
    $display("Test reset done");
  endtask
  // Result monitor takes the oldest note per result
  always @(negedge sys_clk) begin
    if (conv_done === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected result");
      else chk({result_ch, result_data} === exp_q.pop_front(), "result");
    end
  end
  // Run takes under a hundred cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    {rst, small_variant, cfg_wr, scan_en, ext_clk_sel, ext_clk_detect_mode, crystal_present} = 7'h40;
    {cfg_ch, first_ch, last_ch, cfg_data, cal_mode} = 25'h0000000;
    {gpio_dir, gpio_out_val, ext_level} = 21'h000000;
    void'($urandom(32'h76d1542b));
    do_reset();
    // Every gain and rate code, random mux indices
    for (int g = 0; g < 8; g++) begin
      lp = 3'($urandom);
      ln = 3'($urandom);
      wr(3'h0, mk(1'b0, lp, ln, g[0], g[2:0], g[2:0]));
      chk_path(1'b0, lp, ln, g[0], g[2:0], g[2:0]);
    end
    $display("Test gain and rate done");
    // Second channel differs, first keeps its own
    wr(3'h1, mk(1'b1, 3'h2, 3'h3, 1'b1, 3'h5, 3'h2));
    chk_path(1'b0, lp, ln, 1'b1, 3'h7, 3'h7);
    first_ch <= 3'h1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_path(1'b1, 3'h2, 3'h3, 1'b1, 3'h5, 3'h2);
    $display("Test per channel done");
    // Shared reference pins and missing channels are refused
    wr(3'h1, mk(1'b1, 3'h6, 3'h0, 1'b0, 3'h0, 3'h0));
    chk(cfg_conflict === 1'b1, "ref conflict flag");
    chk_path(1'b1, 3'h2, 3'h3, 1'b1, 3'h5, 3'h2);
    small_variant <= 1'b1;
    repeat (2) @(posedge sys_clk);
    wr(3'h5, mk(1'b0, 3'h0, 3'h1, 1'b0, 3'h0, 3'h7));
    chk(cfg_conflict === 1'b1, "variant refusal");
    small_variant <= 1'b0;
    repeat (2) @(posedge sys_clk);
    wr(3'h5, mk(1'b0, 3'h0, 3'h1, 1'b0, 3'h0, 3'h7));
    chk(cfg_conflict === 1'b0, "large variant accepts");
    $display("Test refusal done");
    // Samples pass through on the active channel
    for (i = 0; i < 3'h4; i++) begin
      v = 16'($urandom);
      exp_q.push_back({3'h1, v});
      i_sensor_model.send(v);
    end
    // Offset correction: first sample seeds the store, later ones subtract it
    cal_mode <= 2'h1;
    for (int k = 0; k < 3; k++) begin
      v = 16'($urandom);
      exp_q.push_back({3'h1, (k == 0) ? v : 16'(v - (w >> 8))});
      w = v;
      if (k == 2) cal_mode <= 2'h3;
      i_sensor_model.send(v);
    end
    repeat (2) @(posedge sys_clk);
    chk(exp_q.size() == 0, "results missing");
    $display("Test samples done");
    // General pins: drive where enabled, read the wire
    gpio_dir     <= 7'($urandom);
    gpio_out_val <= 7'($urandom);
    ext_level    <= 7'($urandom);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(general_pins_oe === gpio_dir && (general_pins_out & gpio_dir) === (gpio_out_val & gpio_dir), "pin drive");
    chk(gpio_read_val === ((gpio_dir & gpio_out_val) | (~gpio_dir & ext_level)), "pin read");
    $display("Test pins done");
    // Crystal detection stops the internal oscillator
    ext_clk_sel         <= 1'b1;
    ext_clk_detect_mode <= 1'b1;
    crystal_present     <= 1'b1;
    for (int k = 0; k < 10 && int_osc_en !== 1'b0; k++) @(posedge sys_clk);
    #1;
    chk(use_ext_clk === 1'b1 && int_osc_en === 1'b0, "crystal switch");
    $display("Test crystal done");
    ext_clk_sel         <= 1'b0;
    ext_clk_detect_mode <= 1'b0;
    crystal_present     <= 1'b0;
    do_reset();
    stop_test();
  end
endmodule
